// ==== design/nwg_pkg.sv ====
`default_nettype none
package nwg_pkg;
    // Register word offsets on the plain register port
    localparam int ADDR_W = 10;
    localparam logic [9:0] OFS_CTRL = 10'h1C0;
    localparam logic [9:0] OFS_EXEMPT_BASE = 10'h200;
    localparam logic [9:0] OFS_LOG_STAT = 10'h220;
    localparam logic [9:0] OFS_LOG_REFUSED = 10'h221;
    localparam logic [9:0] OFS_LOG_BASE = 10'h240;
    // Control word layout
    localparam int CTRL_EN_BIT = 15;
    localparam int CNT_W = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] EXEMPT_RESET = 16'h0000;
    localparam logic [7:0] NODE_ANY = 8'hFF;
    localparam int MAX_EXEMPT = 32;
    // Answer codes for an executed and a refused frame
    localparam logic [15:0] RESP_OK = 16'h0000;
    localparam logic [15:0] RESP_PROTECTED = 16'h2130;
    // Guarded command codes
    localparam logic [15:0] CMD_MEM_WRITE = 16'h0102;
    localparam logic [15:0] CMD_MEM_FILL = 16'h0103;
    localparam logic [15:0] CMD_MEM_XFER = 16'h0105;
    localparam logic [15:0] CMD_PAR_WRITE = 16'h0202;
    localparam logic [15:0] CMD_PAR_FILL = 16'h0203;
    localparam logic [15:0] CMD_PRG_WRITE = 16'h0307;
    localparam logic [15:0] CMD_PRG_CLEAR = 16'h0308;
    localparam logic [15:0] CMD_RUN = 16'h0401;
    localparam logic [15:0] CMD_STOP = 16'h0402;
    localparam logic [15:0] CMD_CLK_WRITE = 16'h0702;
    localparam logic [15:0] CMD_ACC_ACQ = 16'h0C01;
    localparam logic [15:0] CMD_ERR_CLEAR = 16'h2101;
    localparam logic [15:0] CMD_ELOG_CLEAR = 16'h2103;
    localparam logic [15:0] CMD_FILE_WRITE = 16'h2203;
    localparam logic [15:0] CMD_FILE_FMT = 16'h2204;
    localparam logic [15:0] CMD_FILE_DEL = 16'h2205;
    localparam logic [15:0] CMD_FILE_COPY = 16'h2207;
    localparam logic [15:0] CMD_FILE_REN = 16'h2208;
    localparam logic [15:0] CMD_DIR_EDIT = 16'h2215;
    localparam logic [15:0] CMD_MEM_TO_FILE = 16'h220A;
    localparam logic [15:0] CMD_PAR_TO_FILE = 16'h220B;
    localparam logic [15:0] CMD_PRG_TO_FILE = 16'h220C;
    localparam logic [15:0] CMD_FORCE = 16'h2301;
    localparam logic [15:0] CMD_FORCE_CANCEL = 16'h2302;

    // One incoming request at the guard
    typedef struct packed {
        logic valid;
        logic is_frame;
        logic via_net;
        logic is_local;
        logic [15:0] code;
        logic [7:0] src_net;
        logic [7:0] src_node;
    } nwg_req_t;

    // Verdict handed to the execution logic
    typedef struct packed {
        logic valid;
        logic execute;
        logic refused;
        logic [15:0] resp_code;
    } nwg_verdict_t;
endpackage
`default_nettype wire

// ==== design/nwg_guard.sv ====
// Behaviour
// - Enable bit is control word bit 15
// - Direct serial frames are never refused
// - Read commands always execute
// - Enable bit resets to zero
// - Up to 32 exempt sources may write
// - Entry is network high byte, node low
// - Control low byte holds exempt count
// - Count zero refuses all but local node
// - List matters only while enabled
// - Refuse memory write, fill, transfer
// - Refuse parameter write and fill
// - Refuse program write and clear
// - Refuse run, stop and clock write
// - Refuse access acquire and error clears
// - Refuse file write, format, delete
// - Refuse file copy, rename, directory edit
// - Refuse area to file transfers
// - Refuse forced set/reset and cancel
// - Log every network write, readable
// - Only command frames are guarded
// - Gateway entry counts as network traffic
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module nwg_guard #(
    parameter int NUM_EXEMPT = 32,
    parameter int LOG_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Requests from the serial and network sides
    input wire nwg_pkg::nwg_req_t req,
    // Verdict towards execution logic
    output var nwg_pkg::nwg_verdict_t verdict,
    // Register port
    input wire logic [nwg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    localparam int LW = $clog2(LOG_DEPTH);

    // Elaboration stops on sizes the logic cannot serve
    if (NUM_EXEMPT < 1 || NUM_EXEMPT > nwg_pkg::MAX_EXEMPT) begin : g_bad_num
        $error("NUM_EXEMPT out of range");
    end
    if (LOG_DEPTH < 2 || LOG_DEPTH > 16 ||
        (1 << LW) != LOG_DEPTH) begin : g_bad_depth
        $error("LOG_DEPTH must be a power of two up to 16");
    end

    function automatic logic guarded_cmd(input logic [15:0] c);
        case (c)
            nwg_pkg::CMD_MEM_WRITE, nwg_pkg::CMD_MEM_FILL,
            nwg_pkg::CMD_MEM_XFER: guarded_cmd = 1'b1;
            nwg_pkg::CMD_PAR_WRITE,
            nwg_pkg::CMD_PAR_FILL: guarded_cmd = 1'b1;
            nwg_pkg::CMD_PRG_WRITE,
            nwg_pkg::CMD_PRG_CLEAR: guarded_cmd = 1'b1;
            nwg_pkg::CMD_RUN, nwg_pkg::CMD_STOP,
            nwg_pkg::CMD_CLK_WRITE: guarded_cmd = 1'b1;
            nwg_pkg::CMD_ACC_ACQ, nwg_pkg::CMD_ERR_CLEAR,
            nwg_pkg::CMD_ELOG_CLEAR: guarded_cmd = 1'b1;
            nwg_pkg::CMD_FILE_WRITE, nwg_pkg::CMD_FILE_FMT,
            nwg_pkg::CMD_FILE_DEL: guarded_cmd = 1'b1;
            nwg_pkg::CMD_FILE_COPY, nwg_pkg::CMD_FILE_REN,
            nwg_pkg::CMD_DIR_EDIT: guarded_cmd = 1'b1;
            nwg_pkg::CMD_MEM_TO_FILE, nwg_pkg::CMD_PAR_TO_FILE,
            nwg_pkg::CMD_PRG_TO_FILE: guarded_cmd = 1'b1;
            nwg_pkg::CMD_FORCE,
            nwg_pkg::CMD_FORCE_CANCEL: guarded_cmd = 1'b1;
            default: guarded_cmd = 1'b0;
        endcase
    endfunction

    function automatic logic in_window(input logic [9:0] a,
                                       input logic [9:0] base,
                                       input int unsigned len);
        in_window = ({22'h0, a} >= {22'h0, base}) &&
                    ({22'h0, a} < {22'h0, base} + len);
    endfunction

    // Registers
    logic [15:0] ctrl_r;
    logic [15:0] exempt_r [NUM_EXEMPT];
    logic [15:0] log_code_r [LOG_DEPTH];
    logic [15:0] log_src_r [LOG_DEPTH];
    logic [LOG_DEPTH-1:0] log_refused_r;
    logic [LW-1:0] log_wptr_r;
    logic [LW:0] log_count_r;
    nwg_pkg::nwg_verdict_t verdict_r;
    logic [15:0] rdata_r;

    // Control decode
    wire guard_en = ctrl_r[nwg_pkg::CTRL_EN_BIT];
    wire [nwg_pkg::CNT_W-1:0] exempt_cnt = ctrl_r[nwg_pkg::CNT_W-1:0];

    // Exempt match, one comparator per entry
    logic [NUM_EXEMPT-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NUM_EXEMPT; g++) begin : g_match
            wire [7:0] e_net = exempt_r[g][15:8];
            wire [7:0] e_node = exempt_r[g][7:0];
            wire live = (exempt_cnt > 8'(g));
            assign hit[g] = live && (e_net == req.src_net) &&
                ((e_node == nwg_pkg::NODE_ANY) || (e_node == req.src_node));
        end
    endgenerate

    // Acceptance; a gateway hop arrives here flagged as network
    wire is_guarded = guarded_cmd(req.code);
    wire net_write = req.valid && req.is_frame &&
        req.via_net && is_guarded;
    wire exempt_hit = |hit;
    wire refuse = net_write && guard_en && !req.is_local && !exempt_hit;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            verdict_r <= '0;
        end else begin
            verdict_r.valid <= req.valid;
            verdict_r.execute <= req.valid && !refuse;
            verdict_r.refused <= refuse;
            verdict_r.resp_code <= refuse ? nwg_pkg::RESP_PROTECTED
                                          : nwg_pkg::RESP_OK;
        end
    end
    assign verdict = verdict_r;

    // Register write decode
    wire wr_ctrl = reg_wr && (reg_addr == nwg_pkg::OFS_CTRL);
    wire wr_exempt = reg_wr &&
        in_window(reg_addr, nwg_pkg::OFS_EXEMPT_BASE, NUM_EXEMPT);
    wire [9:0] ex_idx = reg_addr - nwg_pkg::OFS_EXEMPT_BASE;
    wire log_clr = reg_wr && (reg_addr == nwg_pkg::OFS_LOG_STAT);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_r <= nwg_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_EXEMPT; i++)
                exempt_r[i] <= nwg_pkg::EXEMPT_RESET;
        end else if (wr_exempt) begin
            exempt_r[ex_idx[4:0]] <= reg_wdata;
        end
    end

    // Event log ring; a record in the clear cycle survives as entry one
    wire [LW:0] log_cnt_nxt = log_clr ? (LW+1)'(net_write)
        : (net_write && log_count_r != (LW+1)'(LOG_DEPTH))
        ? log_count_r + 1'b1 : log_count_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            log_wptr_r <= '0;
            log_count_r <= '0;
            log_refused_r <= '0;
        end else begin
            log_count_r <= log_cnt_nxt;
            if (net_write) begin
                log_wptr_r <= log_wptr_r + 1'b1;
                log_refused_r[log_wptr_r] <= refuse;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (net_write) begin
            log_code_r[log_wptr_r] <= req.code;
            log_src_r[log_wptr_r] <= {req.src_net, req.src_node};
        end
    end

    // Read selection
    wire rd_ex = in_window(reg_addr, nwg_pkg::OFS_EXEMPT_BASE, NUM_EXEMPT);
    wire rd_log = in_window(reg_addr, nwg_pkg::OFS_LOG_BASE, 2 * LOG_DEPTH);
    wire [9:0] lg_idx = reg_addr - nwg_pkg::OFS_LOG_BASE;
    wire [LW-1:0] lg_ent = lg_idx[LW:1];
    wire [15:0] stat_word = 16'({log_wptr_r, 8'h00}) |
                            16'(log_count_r);
    wire [15:0] rd_word =
        (reg_addr == nwg_pkg::OFS_CTRL) ? ctrl_r :
        rd_ex ? exempt_r[ex_idx[4:0]] :
        (reg_addr == nwg_pkg::OFS_LOG_STAT) ? stat_word :
        (reg_addr == nwg_pkg::OFS_LOG_REFUSED) ? 16'(log_refused_r) :
        rd_log ? (lg_idx[0] ? log_src_r[lg_ent] : log_code_r[lg_ent]) :
        16'h0000;

    // Read data only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_word : 16'h0000;
        end
    end
    assign reg_rdata = rdata_r;

    // Checks
    property p_en_reset;
        @(posedge clk_sys) !rst_b |=> !ctrl_r[nwg_pkg::CTRL_EN_BIT];
    endproperty
    a_en_reset: assert property (p_en_reset)
        else $error("guard enable not cleared by reset");

    property p_serial_pass;
        @(posedge clk_sys) disable iff (!rst_b)
        req.valid && !req.via_net |=> verdict.execute && !verdict.refused;
    endproperty
    a_serial_pass: assert property (p_serial_pass)
        else $error("serial frame refused");

    property p_read_pass;
        @(posedge clk_sys) disable iff (!rst_b)
        req.valid && !guarded_cmd(req.code) |=> verdict.execute;
    endproperty
    a_read_pass: assert property (p_read_pass)
        else $error("read command not executed");

    property p_off_pass;
        @(posedge clk_sys) disable iff (!rst_b)
        req.valid && !ctrl_r[nwg_pkg::CTRL_EN_BIT] |=> verdict.execute;
    endproperty
    a_off_pass: assert property (p_off_pass)
        else $error("refusal while guard disabled");

    property p_link_pass;
        @(posedge clk_sys) disable iff (!rst_b)
        req.valid && !req.is_frame |=> verdict.execute;
    endproperty
    a_link_pass: assert property (p_link_pass)
        else $error("non-frame write blocked");

    property p_zero_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        net_write && ctrl_r[nwg_pkg::CTRL_EN_BIT] && !req.is_local &&
        exempt_cnt == '0 |=> verdict.refused && !verdict.execute;
    endproperty
    a_zero_refuse: assert property (p_zero_refuse)
        else $error("write passed with empty exempt list");

    property p_exempt_pass;
        @(posedge clk_sys) disable iff (!rst_b)
        req.valid && |hit |=> verdict.execute;
    endproperty
    a_exempt_pass: assert property (p_exempt_pass)
        else $error("exempt source refused");

    property p_refuse_code;
        @(posedge clk_sys) disable iff (!rst_b)
        refuse |=> verdict.valid && !verdict.execute &&
                   verdict.resp_code == nwg_pkg::RESP_PROTECTED;
    endproperty
    a_refuse_code: assert property (p_refuse_code)
        else $error("refused frame lacks error answer");

    property p_log_step;
        @(posedge clk_sys) disable iff (!rst_b)
        net_write |=> log_wptr_r == $past(log_wptr_r) + 1'b1 &&
                      log_code_r[$past(log_wptr_r)] == $past(req.code);
    endproperty
    a_log_step: assert property (p_log_step)
        else $error("network write not logged");

    property p_ctrl_read;
        @(posedge clk_sys) disable iff (!rst_b)
        reg_rd && !reg_wr && reg_addr == nwg_pkg::OFS_CTRL
        |=> reg_rdata == $past(ctrl_r);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control word read mismatch");

    // Stranger: net frame, not local, guard on, empty exempt list
    wire stranger = req.valid && req.is_frame && req.via_net &&
        !req.is_local && guard_en && (exempt_cnt == '0);

    property p_mem_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_MEM_WRITE ||
            req.code == nwg_pkg::CMD_MEM_FILL ||
            req.code == nwg_pkg::CMD_MEM_XFER) |=> verdict.refused;
    endproperty
    a_mem_refuse: assert property (p_mem_refuse)
        else $error("memory write passed while guarded");

    property p_par_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_PAR_WRITE ||
            req.code == nwg_pkg::CMD_PAR_FILL) |=> verdict.refused;
    endproperty
    a_par_refuse: assert property (p_par_refuse)
        else $error("parameter write passed while guarded");

    property p_prg_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_PRG_WRITE ||
            req.code == nwg_pkg::CMD_PRG_CLEAR) |=> verdict.refused;
    endproperty
    a_prg_refuse: assert property (p_prg_refuse)
        else $error("program write passed while guarded");

    property p_mode_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_RUN ||
            req.code == nwg_pkg::CMD_STOP ||
            req.code == nwg_pkg::CMD_CLK_WRITE) |=> verdict.refused;
    endproperty
    a_mode_refuse: assert property (p_mode_refuse)
        else $error("mode or clock change passed while guarded");

    property p_acc_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_ACC_ACQ ||
            req.code == nwg_pkg::CMD_ERR_CLEAR ||
            req.code == nwg_pkg::CMD_ELOG_CLEAR) |=> verdict.refused;
    endproperty
    a_acc_refuse: assert property (p_acc_refuse)
        else $error("access or error clear passed while guarded");

    property p_file_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_FILE_WRITE ||
            req.code == nwg_pkg::CMD_FILE_FMT ||
            req.code == nwg_pkg::CMD_FILE_DEL) |=> verdict.refused;
    endproperty
    a_file_refuse: assert property (p_file_refuse)
        else $error("file write passed while guarded");

    property p_fedit_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_FILE_COPY ||
            req.code == nwg_pkg::CMD_FILE_REN ||
            req.code == nwg_pkg::CMD_DIR_EDIT) |=> verdict.refused;
    endproperty
    a_fedit_refuse: assert property (p_fedit_refuse)
        else $error("file edit passed while guarded");

    property p_xfer_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_MEM_TO_FILE ||
            req.code == nwg_pkg::CMD_PAR_TO_FILE ||
            req.code == nwg_pkg::CMD_PRG_TO_FILE) |=> verdict.refused;
    endproperty
    a_xfer_refuse: assert property (p_xfer_refuse)
        else $error("area to file transfer passed while guarded");

    property p_force_refuse;
        @(posedge clk_sys) disable iff (!rst_b)
        stranger && (req.code == nwg_pkg::CMD_FORCE ||
            req.code == nwg_pkg::CMD_FORCE_CANCEL) |=> verdict.refused;
    endproperty
    a_force_refuse: assert property (p_force_refuse)
        else $error("forced set or cancel passed while guarded");
endmodule
`default_nettype wire

// ==== verification/nwg_node_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module nwg_node_model (
    // Clock
    input wire logic clk_sys,
    // Request towards the guard
    output var nwg_pkg::nwg_req_t req
);
    initial req = '0;

    // Idle fields flip so a stale frame cannot pass for a live one
    task automatic send(input logic [2:0] f, input logic [15:0] c,
                        input logic [15:0] src);
        nwg_pkg::nwg_req_t r;
        r = {1'b1, f, c, src};
        @(posedge clk_sys);
        req <= r;
        @(posedge clk_sys);
        req <= {1'b0, ~r[34:0]};
    endtask
endmodule
`default_nettype wire

// ==== verification/network_write_command_guard_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module network_write_command_guard_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    nwg_pkg::nwg_req_t req;
    nwg_pkg::nwg_verdict_t verdict;
    logic [9:0] reg_addr = 10'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [18:0] rd;
    logic [3:0] p;
    // Valid with execute, and valid with refused plus protected answer
    localparam logic [18:0] RUN = 19'h60000;
    localparam logic [18:0] NO = 19'h52130;
    localparam logic [15:0] CODES [24] = '{16'h0102, 16'h0103, 16'h0105,
        16'h0202, 16'h0203, 16'h0307, 16'h0308, 16'h0401, 16'h0402,
        16'h0702, 16'h0C01, 16'h2101, 16'h2103, 16'h2203, 16'h2204,
        16'h2205, 16'h2207, 16'h2208, 16'h2215, 16'h220A, 16'h220B,
        16'h220C, 16'h2301, 16'h2302};

    always #5 clk_sys = ~clk_sys;

    nwg_guard dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .req(req),
        .verdict(verdict),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    nwg_node_model node (
        .clk_sys(clk_sys),
        .req(req)
    );

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Run is about 120 cycles; the ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rdw(input logic [9:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd = {3'b000, reg_rdata};
    endtask

    // Flags are frame, via network, local source
    task automatic cmd(input logic [2:0] f, input logic [15:0] c,
                       input logic [15:0] src, input logic [18:0] exp);
        node.send(f, c, src);
        #1;
        chk(verdict, exp);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdw(nwg_pkg::OFS_CTRL);
        chk(rd, 19'h00000);
        wr(10'h3FF, 16'hFFFF);
        rdw(10'h3FF);
        chk(rd, 19'h00000);
        cmd(3'b110, 16'h0102, 16'h0A0B, RUN);
        wr(nwg_pkg::OFS_CTRL, 16'h8000);
        rdw(nwg_pkg::OFS_CTRL);
        chk(rd, 19'h08000);
        for (int i = 0; i < 13; i++) begin
            cmd(3'b110, CODES[i], 16'h0A0B, NO);
        end
        for (int i = 13; i < 24; i++) begin
            cmd(3'b110, CODES[i], 16'h0A0B, NO);
        end
        cmd(3'b110, 16'h0101, 16'h0A0B, RUN);
        cmd(3'b100, 16'h0102, 16'h0A0B, RUN);
        cmd(3'b010, 16'h0102, 16'h0A0B, RUN);
        cmd(3'b111, 16'h0102, 16'h0A0B, RUN);
        wr(10'h200, 16'h0105);
        wr(10'h201, 16'h02FF);
        wr(nwg_pkg::OFS_CTRL, 16'h8001);
        rdw(10'h201);
        chk(rd, 19'h002FF);
        cmd(3'b110, 16'h0702, 16'h0105, RUN);
        cmd(3'b110, 16'h0702, 16'h0106, NO);
        cmd(3'b110, 16'h0702, 16'h0233, NO);
        wr(nwg_pkg::OFS_CTRL, 16'h8002);
        cmd(3'b110, 16'h0702, 16'h0233, RUN);
        cmd(3'b110, 16'h0702, 16'h0333, NO);
        wr(nwg_pkg::OFS_CTRL, 16'h0002);
        cmd(3'b110, 16'h0702, 16'h0A0B, RUN);
        // 32 logged writes so far: log full, pointer wrapped to 0
        rdw(nwg_pkg::OFS_LOG_STAT);
        chk(rd, 19'h00010);
        wr(nwg_pkg::OFS_CTRL, 16'h8000);
        wr(nwg_pkg::OFS_LOG_STAT, 16'h0000);
        rdw(nwg_pkg::OFS_LOG_STAT);
        p = rd[11:8];
        chk(rd & 19'h0001F, 19'h00000);
        cmd(3'b110, 16'h2301, 16'h0304, NO);
        rdw(nwg_pkg::OFS_LOG_STAT);
        chk(rd & 19'h0001F, 19'h00001);
        rdw(nwg_pkg::OFS_LOG_BASE + {5'b00000, p, 1'b0});
        chk(rd, 19'h02301);
        rdw(nwg_pkg::OFS_LOG_BASE + {5'b00000, p, 1'b1});
        chk(rd, 19'h00304);
        rdw(nwg_pkg::OFS_LOG_REFUSED);
        chk({18'h00000, rd[p]}, 19'h00001);
        conclude();
    end
endmodule
`default_nettype wire
